// file: rtl/fpq_pkg.sv
package fpq_pkg;

    localparam logic [7:0] OP_WRSR         = 8'h01;
    localparam logic [7:0] OP_RDSR         = 8'h05;
    localparam logic [7:0] OP_PD_RELEASE   = 8'hAB;
    localparam logic [7:0] OP_PD_ENTER     = 8'hB9;
    localparam logic [7:0] OP_QUAD_ENTER   = 8'h35;
    localparam logic [7:0] OP_QUAD_EXIT    = 8'hF5;
    localparam logic [7:0] OP_QUAD_READ    = 8'hEB;
    localparam logic [7:0] MODE_CONTINUE   = 8'hA5;
    localparam logic [7:0] MODE_STOP       = 8'h00;
    localparam logic [3:0] DQ_ALL_ONES     = 4'hF;

    localparam int         WIP_BIT         = 0;
    localparam int         QE_BIT          = 6;

    // clock counts are last-index values of each phase; the two exit counts are whole clock counts
    localparam logic [3:0] CMD_LAST_SINGLE = 4'h7;
    localparam logic [3:0] CMD_LAST_QUAD   = 4'h1;
    localparam logic [3:0] ADDR_LAST_3B    = 4'h5;
    localparam logic [3:0] ADDR_LAST_4B    = 4'h7;
    localparam logic [3:0] MODE_LAST       = 4'h1;
    localparam logic [3:0] DUMMY_LAST      = 4'h3;
    localparam logic [3:0] EXIT_CLKS_3B    = 4'h8;
    localparam logic [3:0] EXIT_CLKS_4B    = 4'hA;

    localparam logic [3:0] OE_N_NONE       = 4'hF;
    localparam logic [3:0] OE_N_SINGLE     = 4'hD;
    localparam logic [3:0] OE_N_QUAD       = 4'h0;

    localparam logic [4:0] RDP_COUNT_DEF   = 5'h1D;
    localparam logic [1:0] RDP_UNIT_DEF    = 2'h1;
    localparam int         CLK_PERIOD_NS   = 20;
    localparam int         UNIT0_NS        = 128;
    localparam int         UNIT1_NS        = 1000;
    localparam int         UNIT2_NS        = 8000;
    localparam int         UNIT3_NS        = 64000;
    localparam int         REC_W           = 17;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_MODE   = 3'b011,
        ST_DUMMY  = 3'b100,
        ST_STAT   = 3'b101,
        ST_WRSR   = 3'b110,
        ST_IGNORE = 3'b111
    } fpq_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] dq;
    } fpq_pins_t;

    // recovery time rounded up so the busy window never ends early
    function automatic logic [REC_W-1:0] rec_cycles(input logic [4:0] cnt,
                                                     input logic [1:0] unit);
        int ns;
        ns = UNIT0_NS;
        case (unit)
            2'h1: ns = UNIT1_NS;
            2'h2: ns = UNIT2_NS;
            2'h3: ns = UNIT3_NS;
            default: ns = UNIT0_NS;
        endcase
        return REC_W'(((int'(cnt) + 1) * ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] dq,
                                            input logic quad);
        return quad ? {sh[3:0], dq} : {sh[6:0], dq[0]};
    endfunction

endpackage

// file: rtl/fpq_ctrl.sv
module fpq_ctrl #(
    parameter logic [4:0] RDP_COUNT = fpq_pkg::RDP_COUNT_DEF,
    parameter logic [1:0] RDP_UNIT  = fpq_pkg::RDP_UNIT_DEF
) (
    // clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // serial flash pins
    input  wire fpq_pkg::fpq_pins_t pins_in,
    output logic [3:0]            dq_out,
    output logic [3:0]            dq_oe_n,
    // device state
    input  wire logic             wip_in,
    output logic                  quad_enable,
    output logic                  deep_power_down,
    output logic                  recovering,
    output logic                  quad_cmd_mode,
    output logic                  cont_read_mode,
    output logic [6:0]            rdp_delay_code,
    // read datapath handoff
    input  wire logic             addr4b,
    output logic                  read_go
);

    localparam logic [fpq_pkg::REC_W-1:0] REC_CYCLES = fpq_pkg::rec_cycles(RDP_COUNT, RDP_UNIT);

    fpq_pkg::fpq_pins_t   sync1_reg;
    fpq_pkg::fpq_pins_t   sync2_reg;
    fpq_pkg::fpq_pins_t   sync3_reg;
    fpq_pkg::fpq_pins_t   filt_reg;
    fpq_pkg::fpq_pins_t   filt_next;
    fpq_pkg::fpq_state_t  state_reg;
    fpq_pkg::fpq_state_t  state_next;
    logic [7:0]           sh_reg;
    logic [3:0]           ccnt_reg;
    logic [3:0]           ones_reg;
    logic [7:0]           stat_sh_reg;
    logic [2:0]           scnt_reg;
    logic                 pend_dpd_reg;
    logic                 pend_qen_reg;
    logic                 pend_qex_reg;
    logic                 cont_pend_reg;
    logic [fpq_pkg::REC_W-1:0] rec_cnt_reg;
    logic [3:0]           dq_out_reg;
    logic [3:0]           dq_oe_n_reg;
    logic                 qe_reg;
    logic                 dpd_reg;
    logic                 recovering_reg;
    logic                 quad_reg;
    logic                 cont_reg;
    logic [6:0]           delay_code_reg;
    logic                 read_go_reg;

    // a level counts only once the second and third stages agree
    assign filt_next = ((sync2_reg ~^ sync3_reg) & sync2_reg)
                     | ((sync2_reg ^ sync3_reg) & filt_reg);

    wire        sclk_rise  = ~filt_reg.sclk & filt_next.sclk & ~filt_next.cs_n;
    wire        sclk_fall  = filt_reg.sclk & ~filt_next.sclk & ~filt_next.cs_n;
    wire        cs_fall    = filt_reg.cs_n & ~filt_next.cs_n;
    wire        cs_rise    = ~filt_reg.cs_n & filt_next.cs_n;
    wire [3:0]  dq_s       = filt_next.dq;

    wire        cmd_quad   = quad_reg;
    wire [7:0]  sh_cmd     = fpq_pkg::shift_in(sh_reg, dq_s, cmd_quad);
    wire [7:0]  sh_quad    = fpq_pkg::shift_in(sh_reg, dq_s, 1'b1);
    wire [3:0]  cmd_last   = cmd_quad ? fpq_pkg::CMD_LAST_QUAD : fpq_pkg::CMD_LAST_SINGLE;
    wire        cmd_done   = ccnt_reg == cmd_last;
    wire [3:0]  addr_last  = addr4b ? fpq_pkg::ADDR_LAST_4B : fpq_pkg::ADDR_LAST_3B;
    wire [3:0]  exit_clks  = addr4b ? fpq_pkg::EXIT_CLKS_4B : fpq_pkg::EXIT_CLKS_3B;
    wire [3:0]  ccnt_inc   = ccnt_reg + 4'h1;

    wire        ones_now   = cont_reg && (dq_s == fpq_pkg::DQ_ALL_ONES);
    // one clock without all ones spoils the frame for good; the count parks at all ones
    wire        ones_dead  = ones_reg == '1;
    wire [3:0]  ones_next  = (ones_now && !ones_dead) ? ones_reg + 4'h1 : '1;
    wire        ones_exit  = ones_now && !ones_dead && (ones_next == exit_clks)
                           && (state_reg == fpq_pkg::ST_ADDR || state_reg == fpq_pkg::ST_MODE);

    // quad reads depend on the host having set quad enable or entered quad command mode
    wire        quad_ok    = qe_reg | quad_reg;

    wire [7:0]  status_now = (8'(wip_in) << fpq_pkg::WIP_BIT) | (8'(qe_reg) << fpq_pkg::QE_BIT);
    wire [7:0]  stat_src   = (scnt_reg == 3'h0) ? status_now : stat_sh_reg;

    // command decode on the last command clock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fpq_pkg::ST_CMD: begin
                if (cmd_done) begin
                    state_next = fpq_pkg::ST_IGNORE;
                    if (!dpd_reg) begin
                        case (sh_cmd)
                            fpq_pkg::OP_RDSR: state_next = fpq_pkg::ST_STAT;
                            fpq_pkg::OP_WRSR: state_next = fpq_pkg::ST_WRSR;
                            fpq_pkg::OP_QUAD_READ:
                                state_next = quad_ok ? fpq_pkg::ST_ADDR : fpq_pkg::ST_IGNORE;
                            default: state_next = fpq_pkg::ST_IGNORE;
                        endcase
                    end
                end
            end
            fpq_pkg::ST_ADDR: begin
                if (ones_exit) begin
                    state_next = fpq_pkg::ST_IGNORE;
                end else if (ccnt_reg == addr_last) begin
                    state_next = fpq_pkg::ST_MODE;
                end
            end
            fpq_pkg::ST_MODE: begin
                if (ones_exit) begin
                    state_next = fpq_pkg::ST_IGNORE;
                end else if (ccnt_reg == fpq_pkg::MODE_LAST) begin
                    state_next = fpq_pkg::ST_DUMMY;
                end
            end
            fpq_pkg::ST_DUMMY: begin
                if (ccnt_reg == fpq_pkg::DUMMY_LAST) begin
                    state_next = fpq_pkg::ST_IGNORE;
                end
            end
            fpq_pkg::ST_WRSR: begin
                if (cmd_done) begin
                    state_next = fpq_pkg::ST_IGNORE;
                end
            end
            fpq_pkg::ST_STAT:   state_next = fpq_pkg::ST_STAT;
            fpq_pkg::ST_IGNORE: state_next = fpq_pkg::ST_IGNORE;
            fpq_pkg::ST_IDLE:   state_next = fpq_pkg::ST_IDLE;
            default:            state_next = fpq_pkg::ST_IDLE;
        endcase
    end

    wire        phase_end  = state_next != state_reg;
    wire [7:0]  sh_next    = (state_reg == fpq_pkg::ST_ADDR || state_reg == fpq_pkg::ST_MODE)
                           ? sh_quad : sh_cmd;
    wire        is_op      = (state_reg == fpq_pkg::ST_CMD) && cmd_done;
    wire        mode_done  = (state_reg == fpq_pkg::ST_MODE) && (ccnt_reg == fpq_pkg::MODE_LAST);

    // pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
            filt_reg  <= '1;
        end else if (ce) begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
        end
    end

    // transaction sequencing on serial clock edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg     <= fpq_pkg::ST_IDLE;
            sh_reg        <= 8'h00;
            ccnt_reg      <= 4'h0;
            ones_reg      <= 4'h0;
            cont_pend_reg <= 1'b0;
        end else if (ce) begin
            if (cs_rise) begin
                state_reg <= fpq_pkg::ST_IDLE;
            end else if (cs_fall) begin
                state_reg     <= cont_reg ? fpq_pkg::ST_ADDR : fpq_pkg::ST_CMD;
                cont_pend_reg <= cont_reg;
                sh_reg        <= 8'h00;
                ccnt_reg      <= 4'h0;
                ones_reg      <= 4'h0;
            end else if (sclk_rise) begin
                state_reg <= state_next;
                sh_reg    <= sh_next;
                ccnt_reg  <= phase_end ? 4'h0 : ccnt_inc;
                ones_reg  <= ones_next;
                if (ones_exit) begin
                    cont_pend_reg <= 1'b0;
                end else if (mode_done) begin
                    // any other byte also drops it
                    cont_pend_reg <= (sh_quad == fpq_pkg::MODE_CONTINUE);
                end
            end
        end
    end

    // pending mode changes, applied when chip select rises
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pend_dpd_reg <= 1'b0;
            pend_qen_reg <= 1'b0;
            pend_qex_reg <= 1'b0;
        end else if (ce) begin
            if (cs_rise || cs_fall) begin
                pend_dpd_reg <= 1'b0;
                pend_qen_reg <= 1'b0;
                pend_qex_reg <= 1'b0;
            end else if (sclk_rise && is_op && !dpd_reg) begin
                pend_dpd_reg <= sh_cmd == fpq_pkg::OP_PD_ENTER;
                pend_qen_reg <= sh_cmd == fpq_pkg::OP_QUAD_ENTER;
                pend_qex_reg <= sh_cmd == fpq_pkg::OP_QUAD_EXIT;
            end
        end
    end

    // operating modes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dpd_reg  <= 1'b0;
            quad_reg <= 1'b0;
            cont_reg <= 1'b0;
            qe_reg   <= 1'b0;
        end else if (ce) begin
            if (cs_rise) begin
                if (pend_dpd_reg) begin
                    dpd_reg <= 1'b1;
                end
                if (pend_qen_reg) begin
                    quad_reg <= 1'b1;
                end
                if (pend_qex_reg) begin
                    quad_reg <= 1'b0;
                end
                cont_reg <= cont_pend_reg;
            end else if (sclk_rise && is_op && dpd_reg && sh_cmd == fpq_pkg::OP_PD_RELEASE) begin
                // only the release opcode is heard here
                dpd_reg <= 1'b0;
            end else if (sclk_rise && state_reg == fpq_pkg::ST_WRSR && cmd_done && !wip_in) begin
                // quad enable written from bit 6
                qe_reg <= sh_cmd[fpq_pkg::QE_BIT];
            end
        end
    end

    // recovery window after release; host must stay quiet meanwhile
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rec_cnt_reg    <= '0;
            recovering_reg <= 1'b0;
            delay_code_reg <= 7'h00;
        end else if (ce) begin
            delay_code_reg <= {RDP_UNIT, RDP_COUNT};
            if (sclk_rise && is_op && dpd_reg && sh_cmd == fpq_pkg::OP_PD_RELEASE) begin
                rec_cnt_reg    <= REC_CYCLES;
                recovering_reg <= 1'b1;
            end else if (rec_cnt_reg != '0) begin
                rec_cnt_reg    <= rec_cnt_reg - 1'b1;
                recovering_reg <= rec_cnt_reg != 1;
            end
        end
    end

    // status output, shifted on falling serial clock edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_sh_reg <= 8'h00;
            scnt_reg    <= 3'h0;
            dq_out_reg  <= 4'h0;
            dq_oe_n_reg <= fpq_pkg::OE_N_NONE;
        end else if (ce) begin
            if (cs_rise || cs_fall) begin
                scnt_reg    <= 3'h0;
                dq_oe_n_reg <= fpq_pkg::OE_N_NONE;
            end else if (sclk_fall && state_reg == fpq_pkg::ST_STAT) begin
                if (cmd_quad) begin
                    dq_out_reg  <= stat_src[7:4];
                    stat_sh_reg <= {stat_src[3:0], 4'h0};
                    scnt_reg    <= {2'b00, ~scnt_reg[0]};
                    dq_oe_n_reg <= fpq_pkg::OE_N_QUAD;
                end else begin
                    dq_out_reg  <= {2'b00, stat_src[7], 1'b0};
                    stat_sh_reg <= {stat_src[6:0], 1'b0};
                    scnt_reg    <= scnt_reg + 3'h1;
                    dq_oe_n_reg <= fpq_pkg::OE_N_SINGLE;
                end
            end
        end
    end

    // one-cycle strobe when the dummy phase ends
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_go_reg <= 1'b0;
        end else if (ce) begin
            read_go_reg <= sclk_rise && state_reg == fpq_pkg::ST_DUMMY
                        && ccnt_reg == fpq_pkg::DUMMY_LAST;
        end
    end

    assign dq_out          = dq_out_reg;
    assign dq_oe_n         = dq_oe_n_reg;
    assign quad_enable     = qe_reg;
    assign deep_power_down = dpd_reg;
    assign recovering      = recovering_reg;
    assign quad_cmd_mode   = quad_reg;
    assign cont_read_mode  = cont_reg;
    assign rdp_delay_code  = delay_code_reg;
    assign read_go         = read_go_reg;

endmodule

// file: verif/fpq_ctrl_props.sv
module fpq_ctrl_props #(
    parameter logic [4:0] RDP_COUNT = fpq_pkg::RDP_COUNT_DEF,
    parameter logic [1:0] RDP_UNIT  = fpq_pkg::RDP_UNIT_DEF
) (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               rst_n,
    // pins
    input wire fpq_pkg::fpq_pins_t pins_in,
    input wire logic [3:0]         dq_oe_n,
    // device state
    input wire logic               quad_enable,
    input wire logic               deep_power_down,
    input wire logic               recovering,
    input wire logic               quad_cmd_mode,
    input wire logic               cont_read_mode,
    input wire logic [6:0]         rdp_delay_code,
    input wire logic               read_go
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT_NS = (RDP_UNIT == 2'h0) ? fpq_pkg::UNIT0_NS :
                             (RDP_UNIT == 2'h1) ? fpq_pkg::UNIT1_NS :
                             (RDP_UNIT == 2'h2) ? fpq_pkg::UNIT2_NS : fpq_pkg::UNIT3_NS;
    localparam int REC = ((int'(RDP_COUNT) + 1) * UNIT_NS + fpq_pkg::CLK_PERIOD_NS - 1)
                         / fpq_pkg::CLK_PERIOD_NS;
    int rec_cnt_reg;

    // window too long for a repetition, so it is counted here
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !recovering) begin
            rec_cnt_reg <= 0;
        end else begin
            rec_cnt_reg <= rec_cnt_reg + 1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_cs_idle;
        pins_in.cs_n [*8];
    endsequence
    sequence s_rec_start;
        ##[0:1] recovering;
    endsequence

    a_delay_code_fixed: assert property ($past(rst_n) |-> rdp_delay_code == {RDP_UNIT, RDP_COUNT})
        else $error("delay code differs from its parameters");
    a_recover_len: assert property ($fell(recovering) |-> rec_cnt_reg == REC)
        else $error("recovery window has the wrong length");
    a_release_starts_rec: assert property ($fell(deep_power_down) |-> s_rec_start)
        else $error("release did not start recovery");
    a_pd_at_cs_high: assert property ($rose(deep_power_down) |-> pins_in.cs_n)
        else $error("power-down entered inside a frame");
    a_quad_at_cs_high: assert property ($changed(quad_cmd_mode) |-> pins_in.cs_n)
        else $error("command mode changed inside a frame");
    a_cont_at_cs_high: assert property ($changed(cont_read_mode) |-> pins_in.cs_n)
        else $error("continuous read changed inside a frame");
    a_pd_stays_silent: assert property (deep_power_down |-> dq_oe_n == fpq_pkg::OE_N_NONE)
        else $error("lanes driven in power-down");
    a_idle_lanes_free: assert property (s_cs_idle |-> dq_oe_n == fpq_pkg::OE_N_NONE)
        else $error("lanes driven while deselected");
    a_cont_needs_qe: assert property ($rose(cont_read_mode) |-> quad_enable || quad_cmd_mode)
        else $error("continuous read without quad enabled");
    a_go_one_pulse: assert property (read_go |=> !read_go)
        else $error("read hand-off pulse too long");
endmodule

bind fpq_ctrl fpq_ctrl_props #(.RDP_COUNT(RDP_COUNT), .RDP_UNIT(RDP_UNIT)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins_in(pins_in), .dq_oe_n(dq_oe_n),
    .quad_enable(quad_enable), .deep_power_down(deep_power_down), .recovering(recovering),
    .quad_cmd_mode(quad_cmd_mode), .cont_read_mode(cont_read_mode),
    .rdp_delay_code(rdp_delay_code), .read_go(read_go));

// file: verif/fpq_host_model.sv
module fpq_host_model (
    // clock and resolved lanes
    input  wire logic       clk_sys,
    input  wire logic [3:0] dq_in,
    // host pins
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      dq
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        dq   = 4'hF;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic frame_start();
        wait_clk(1);
        cs_n <= 1'b0;
        wait_clk(4);
    endtask

    task automatic frame_stop();
        wait_clk(4);
        cs_n <= 1'b1;
        dq   <= ~dq;
        wait_clk(12);
    endtask

    // sclk stands still between frames; sampling late in the high phase covers answer lag
    task automatic shift_byte(input logic [7:0] tx, input logic quad, output logic [7:0] rx);
        int n;
        n  = quad ? 2 : 8;
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            if (quad) begin
                dq <= (i == 0) ? tx[7:4] : tx[3:0];
            end else begin
                dq <= {3'b111, tx[7-i]};
            end
            wait_clk(4);
            sclk <= 1'b1;
            wait_clk(4);
            rx = quad ? {rx[3:0], dq_in} : {rx[6:0], dq_in[1]};
            sclk <= 1'b0;
        end
    endtask
endmodule

// file: verif/fpq_ctrl_bench.sv
module fpq_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] RC = 5'h02;
    localparam logic [1:0] RU = 2'h0;
    // short unit keeps the recovery wait small
    localparam int REC_EXP = ((int'(RC) + 1) * fpq_pkg::UNIT0_NS + fpq_pkg::CLK_PERIOD_NS - 1)
                             / fpq_pkg::CLK_PERIOD_NS;
    logic               clk_sys = 1'b0;
    logic               rst_n   = 1'b0;
    logic               wip_in  = 1'b0;
    logic               addr4b  = 1'b0;
    logic               h_cs_n, h_sclk;
    logic [3:0]         h_dq, dq_out, dq_oe_n, wire_dq;
    logic               quad_enable, deep_power_down, recovering;
    logic               quad_cmd_mode, cont_read_mode, read_go;
    logic [6:0]         rdp_delay_code;
    logic [7:0]         v;
    fpq_pkg::fpq_pins_t pins;
    int                 fails = 0;
    int                 total_checks = 0;
    int                 go_cnt = 0;

    always #10 clk_sys = ~clk_sys;
    // a lane carries the device's value only while its enable is low
    assign wire_dq = (~dq_oe_n & dq_out) | (dq_oe_n & h_dq);
    assign pins    = {h_cs_n, h_sclk, wire_dq};
    always @(posedge clk_sys) begin
        if (read_go === 1'b1) go_cnt++;
    end

    fpq_host_model host (.clk_sys(clk_sys), .dq_in(wire_dq), .cs_n(h_cs_n), .sclk(h_sclk),
                         .dq(h_dq));
    fpq_ctrl #(.RDP_COUNT(RC), .RDP_UNIT(RU)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .pins_in(pins), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .wip_in(wip_in), .quad_enable(quad_enable),
        .deep_power_down(deep_power_down), .recovering(recovering),
        .quad_cmd_mode(quad_cmd_mode), .cont_read_mode(cont_read_mode),
        .rdp_delay_code(rdp_delay_code), .addr4b(addr4b), .read_go(read_go));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic frame1(input logic [7:0] op, input logic quad);
        host.frame_start();
        host.shift_byte(op, quad, v);
        host.frame_stop();
    endtask

    // host polls busy with a status read
    task automatic read_status(input logic quad, output logic [7:0] r);
        host.frame_start();
        host.shift_byte(fpq_pkg::OP_RDSR, quad, v);
        host.shift_byte(8'h00, quad, r);
        host.frame_stop();
    endtask

    task automatic qread(input logic with_op, input logic [7:0] mode);
        host.frame_start();
        if (with_op) host.shift_byte(fpq_pkg::OP_QUAD_READ, 1'b0, v);
        host.shift_byte(8'h12, 1'b1, v);
        host.shift_byte(8'h34, 1'b1, v);
        host.shift_byte(8'h56, 1'b1, v);
        if (addr4b) host.shift_byte(8'h78, 1'b1, v);
        host.shift_byte(mode, 1'b1, v);
        host.shift_byte(8'h00, 1'b1, v);
        host.shift_byte(8'h00, 1'b1, v);
        host.frame_stop();
    endtask

    // lanes held at all ones from the first clock of a continuous frame
    task automatic ones_frame(input int nbytes);
        host.frame_start();
        repeat (nbytes) host.shift_byte(8'hFF, 1'b1, v);
        host.frame_stop();
    endtask

    task automatic t_status();
        check("delay_code", {1'b0, rdp_delay_code}, {1'b0, RU, RC});
        @(posedge clk_sys) wip_in <= 1'b1;
        read_status(1'b0, v);
        check("status_busy", v, 8'h01);
        @(posedge clk_sys) wip_in <= 1'b0;
        // quad enable written before any quad read
        host.frame_start();
        host.shift_byte(fpq_pkg::OP_WRSR, 1'b0, v);
        host.shift_byte(8'h40, 1'b0, v);
        host.frame_stop();
        check("qe", {7'h0, quad_enable}, 8'h01);
        read_status(1'b0, v);
        check("status_qe", v, 8'h40);
        $display("test status done");
    endtask

    task automatic t_power();
        frame1(fpq_pkg::OP_PD_ENTER, 1'b0);
        check("pd_enter", {7'h0, deep_power_down}, 8'h01);
        read_status(1'b0, v);
        check("pd_ignored", v, 8'hFF);
        host.frame_start();
        host.shift_byte(fpq_pkg::OP_PD_RELEASE, 1'b0, v);
        host.wait_clk(4);
        check("pd_left", {6'h0, deep_power_down, recovering}, 8'h01);
        host.frame_stop();
        // host waits out the recovery window
        host.wait_clk(REC_EXP);
        check("rec_over", {7'h0, recovering}, 8'h00);
        $display("test power done");
    endtask

    task automatic t_quad();
        frame1(fpq_pkg::OP_QUAD_ENTER, 1'b0);
        check("qpi_on", {7'h0, quad_cmd_mode}, 8'h01);
        read_status(1'b1, v);
        check("qpi_status", v, 8'h40);
        frame1(fpq_pkg::OP_QUAD_EXIT, 1'b1);
        check("qpi_off", {7'h0, quad_cmd_mode}, 8'h00);
        $display("test quad done");
    endtask

    task automatic t_cont();
        qread(1'b1, fpq_pkg::MODE_CONTINUE);
        check("cont_on", {7'h0, cont_read_mode}, 8'h01);
        qread(1'b0, fpq_pkg::MODE_STOP);
        check("no_opcode_go", go_cnt[7:0], 8'h02);
        check("cont_stop", {7'h0, cont_read_mode}, 8'h00);
        qread(1'b1, fpq_pkg::MODE_CONTINUE);
        qread(1'b0, 8'h5A);
        check("cont_drop", {7'h0, cont_read_mode}, 8'h00);
        qread(1'b1, fpq_pkg::MODE_CONTINUE);
        check("opcode_again", go_cnt[7:0], 8'h05);
        // all-ones for 12 clocks; exit after 8 sends the rest to ignore, so no hand-off may come
        ones_frame(6);
        check("cont_ones", {7'h0, cont_read_mode}, 8'h00);
        check("ones_no_go", go_cnt[7:0], 8'h05);
        @(posedge clk_sys) addr4b <= 1'b1;
        qread(1'b1, fpq_pkg::MODE_CONTINUE);
        check("cont_on_4b", {7'h0, cont_read_mode}, 8'h01);
        ones_frame(7);
        check("cont_ones_4b", {7'h0, cont_read_mode}, 8'h00);
        check("ones_no_go_4b", go_cnt[7:0], 8'h06);
        @(posedge clk_sys) addr4b <= 1'b0;
        $display("test cont done");
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        t_status();
        t_power();
        t_quad();
        t_cont();
        conclude();
    end

    initial begin
        #400000;
        fails++;
        conclude();
    end
endmodule
